// ==== dv/fan_far_side_model.sv ====
// Far side model: a converter that answers start pulses, and three fan tach outputs.
// Assumes it shares clk_sys with the block; its outputs change on the rising edge.
`timescale 1ns/10ps
module fan_far_side_model #(
  parameter int CONV_CYCLES = 20,                 // Conversion time in cycles
  parameter int HALF [3]    = '{2222, 4444, 3333} // Half tach period per fan, cycles
) (
  input  wire logic       clk_sys,   // System clock
  input  wire logic       adc_start, // Start pulse from the block
  input  wire logic [2:0] adc_slot,  // Channel to convert
  output logic            adc_done,  // Result pulse
  output logic      [7:0] adc_code,  // Result code
  output logic      [2:0] fan_tach   // Tach levels with chattering edges
);
  int         conv_left;
  logic [2:0] conv_slot;
  int         ph [3];
  logic       base [3];

  initial begin
    conv_left = 0;
    conv_slot = 3'h0;
    adc_done  = 1'b0;
    adc_code  = 8'h00;
    fan_tach  = 3'h0;
    for (int k = 0; k < 3; k++) begin
      ph[k]   = k * 500;
      base[k] = 1'b0;
    end
  end

  // A fresh start aborts the conversion in flight, as a host read demands
  always @(posedge clk_sys) begin
    adc_done <= 1'b0;
    adc_code <= ~adc_code;  // Garbage between results: the code inverts each cycle, so a stale code returns every other cycle
    if (adc_start) begin
      conv_left = CONV_CYCLES;
      conv_slot = adc_slot;
    end else if (conv_left > 0) begin
      conv_left = conv_left - 1;
      if (conv_left == 0) begin
        adc_done <= 1'b1;
        adc_code <= {conv_slot, 5'h1F};  // Slot 7 gives full scale FFh
      end
    end
  end

  // Slow edges: the level chatters for several cycles after each transition
  always @(posedge clk_sys) begin
    for (int k = 0; k < 3; k++) begin
      ph[k] = (ph[k] + 1) % HALF[k];
      if (ph[k] == 0) base[k] = ~base[k];
      fan_tach[k] <= base[k] ^ (ph[k] > 3 && ph[k] < 12 && ph[k][1]);
    end
  end
endmodule : fan_far_side_model

// ==== dv/fan_tach_and_result_readout_tb_top.sv ====
// Self-checking bench for the monitoring loop, result reads and fan period counts.
// Assumes the far side model supplies converter answers and tach waveforms.
`timescale 1ns/10ps
module fan_tach_and_result_readout_tb_top;
  localparam int         HALF [3] = '{2222, 4444, 3333};
  localparam logic [1:0] CODE [3] = '{2'h0, 2'h2, 2'h1};
  localparam int         LOOP      = 50000;  // Shortened loop period in cycles
  localparam logic [7:0] FAN_LIMIT = 8'hDB;  // Failing-fan limit software would program
  logic       clk_sys  = 1'b0;
  logic       rst      = 1'b1;
  logic       loop_run = 1'b0;
  logic       div_load = 1'b0;
  logic       rd_req   = 1'b0;
  logic [1:0] div_fan1 = 2'h1;
  logic [1:0] div_fan2 = 2'h1;
  logic [3:0] rd_slot  = 4'h0;
  logic [1:0] fan1_div_code, fan2_div_code;
  logic       adc_start, adc_done, rd_valid, slot_done, loop_busy, restarted;
  logic [2:0] adc_slot, fan_tach;
  logic [7:0] adc_code, rd_data, got, exp;
  logic [3:0] slot_idx;
  int         n_errors = 0;
  int         checked  = 0;
  int         cycles   = 0;
  int         n_slots  = 0;

  always #10 clk_sys = ~clk_sys;

  fan_tach_and_result_readout #(.LOOP_CYCLES(LOOP)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .loop_run(loop_run), .div_load(div_load),
    .div_fan1(div_fan1), .div_fan2(div_fan2), .fan1_div_code(fan1_div_code),
    .fan2_div_code(fan2_div_code), .adc_start(adc_start), .adc_slot(adc_slot),
    .adc_done(adc_done), .adc_code(adc_code), .fan_tach(fan_tach), .rd_req(rd_req),
    .rd_slot(rd_slot), .rd_data(rd_data), .rd_valid(rd_valid), .slot_done(slot_done),
    .slot_idx(slot_idx), .loop_busy(loop_busy));

  fan_far_side_model #(.CONV_CYCLES(20), .HALF(HALF)) far_u (
    .clk_sys(clk_sys), .adc_start(adc_start), .adc_slot(adc_slot),
    .adc_done(adc_done), .adc_code(adc_code), .fan_tach(fan_tach));

  task automatic test_done();
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk

  // One read: rd_valid and the restart pulse appear just after the taken edge, for one cycle
  task automatic rd(input logic [3:0] s, output logic [7:0] d, output logic st);
    @(posedge clk_sys);
    #1 rd_req = 1'b1;
    rd_slot = s;
    @(posedge clk_sys);
    #1 rd_req = 1'b0;
    chk({7'h0, rd_valid}, 8'h01, "read valid");
    d  = rd_data;
    st = adc_start;
    @(posedge clk_sys);
    #1 chk({7'h0, rd_valid}, 8'h00, "read valid length");
  endtask : rd

  task automatic load_div(input logic [1:0] a, input logic [1:0] b);
    @(posedge clk_sys);
    #1 div_load = 1'b1;
    div_fan1 = a;
    div_fan2 = b;
    @(posedge clk_sys);
    #1 div_load = 1'b0;
    chk({6'h0, fan1_div_code}, {6'h0, a}, "fan 1 divisor");
    chk({6'h0, fan2_div_code}, {6'h0, b}, "fan 2 divisor");
  endtask : load_div

  // Slots must complete strictly in loop order, one pulse each
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (!rst && slot_done === 1'b1) begin
      chk({4'h0, slot_idx}, 8'(n_slots), "slot order");
      n_slots <= n_slots + 1;
    end
    if (cycles == 90000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    int i;
    int t0;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk({6'h0, fan1_div_code}, 8'h01, "fan 1 divisor reset");
    chk({6'h0, fan2_div_code}, 8'h01, "fan 2 divisor reset");
    for (int c = 0; c < 4; c++) load_div(2'(c), 2'(3 - c));
    load_div(CODE[0], CODE[1]);
    rd(4'hC, got, restarted);
    chk(got, 8'h00, "unmapped slot");
    loop_run = 1'b1;
    i = 0;
    while (adc_start !== 1'b1 && i < 100) begin
      @(posedge clk_sys);
      #1 i++;
    end
    t0 = cycles;
    chk({7'h0, loop_busy}, 8'h01, "loop running");
    repeat (5) @(posedge clk_sys);
    rd(4'h0, got, restarted);
    chk(got, 8'h00, "result before any conversion");
    chk({7'h0, restarted}, 8'h01, "conversion restart after read");
    chk({5'h0, adc_slot}, 8'h00, "restarted channel");
    wait (n_slots == 11);
    // The next loop must begin exactly one loop period after the first one
    i = 0;
    while (adc_start !== 1'b1 && i < LOOP) begin
      @(posedge clk_sys);
      #1 i++;
    end
    checked++;
    if (cycles - t0 != LOOP) begin
      n_errors++;
      $display("wrong value at %0t ns: loop period %0d cycles", $time, cycles - t0);
    end
    loop_run = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h0, loop_busy}, 8'h00, "loop stopped");
    // Results stay readable after the loop stops
    for (int s = 0; s < 8; s++) begin
      rd(4'(s), got, restarted);
      chk(got, {3'(s), 5'h1F}, "analog result");
    end
    // Tick phase against the tach edge may shift the count by one
    for (int k = 0; k < 3; k++) begin
      rd(4'(8 + k), got, restarted);
      exp = 8'(2 * HALF[k] / (fan_mon_pkg::TICK_CYCLES << CODE[k]));
      checked++;
      if (got !== exp && got !== exp + 8'h01 && got !== exp - 8'h01) begin
        n_errors++;
        $display("wrong value at %0t ns: fan %0d count %h near %h", $time, k, got, exp);
      end
      // A healthy fan must stay clear of the failing-fan limit
      checked++;
      if (got >= FAN_LIMIT) begin
        n_errors++;
        $display("wrong value at %0t ns: fan %0d count %h at failure limit", $time, k, got);
      end
    end
    test_done();
  end
endmodule : fan_tach_and_result_readout_tb_top

// ==== pkg/fan_meas_if.sv ====
// Link between the loop sequencer and one fan period counter.
// Assumes both ends share clk_sys.
`timescale 1ns/10ps
interface fan_meas_if;
  logic       start;     // One-cycle pulse: clear and begin a measurement
  logic [1:0] div_code;  // 0..3 selects divisor 1, 2, 4, 8
  logic       done;      // One-cycle pulse: count is valid
  logic [7:0] count;     // Period measured in divided ticks
  modport ctrl    (output start, output div_code, input done, input count);
  modport counter (input start, input div_code, output done, output count);
endinterface : fan_meas_if

// ==== pkg/fan_mon_pkg.sv ====
// Shared constants for the fan tachometer and result readout block.
// Assumes a 50 MHz system clock; all counts are derived from it here.
package fan_mon_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          FAN_BASE_HZ   = 45_000;                 // Counting rate at divisor 1
  localparam int          TICK_CYCLES   = CLK_HZ / FAN_BASE_HZ;   // 1111, rounded down
  localparam int          FILT_NS       = 1000;                   // Tach level must hold this long
  localparam int          FILT_CYCLES   = FILT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int          LOOP_MS       = 1000;                   // Monitoring loop period
  localparam int          LOOP_CYCLES   = LOOP_MS * (CLK_HZ / 1000);
  localparam int          NUM_SLOTS     = 11;
  localparam logic [3:0]  LAST_ADC_SLOT = 4'h7;
  localparam logic [3:0]  FAN_FIRST     = 4'h8;
  localparam logic [3:0]  LAST_SLOT     = 4'hA;
  localparam logic [1:0]  DIV_RESET     = 2'h1;                   // Code 1 selects divisor 2
  localparam logic [1:0]  FAN3_DIV      = 2'h1;                   // Fan 3 always divides by 2
  localparam logic [7:0]  COUNT_MAX     = 8'hFF;
  localparam int          ADC_LSB_UV    = 16_000;                 // 16 mV per code step
  localparam int          ADC_FULL_MV   = 4080;                   // Code FFh
endpackage : fan_mon_pkg

// ==== rtl/fan_period_counter.sv ====
// Measures one period of a conditioned tach input in divided oscillator ticks.
// Assumes the tach input is synchronous to clk_sys.
`timescale 1ns/10ps
module fan_period_counter (
  input  wire logic clk_sys,          // System clock
  input  wire logic rst,              // Synchronous reset, active high
  input  wire logic tach,             // Raw tach level
  fan_meas_if.counter meas            // Start, divisor, result
);
  typedef enum logic [2:0] {C_IDLE = 3'h1, C_ARM = 3'h2, C_COUNT = 3'h4} cnt_st_t;
  typedef struct packed {
    cnt_st_t    st;
    logic [7:0] filt;
    logic       level;
    logic [13:0] pre;
    logic [7:0] count;
    logic       done;
  } cnt_state_t;

  cnt_state_t q, next_q;
  logic [13:0] tick_limit;
  logic        rise;
  logic        tick;

  // Slower count rate for larger divisors keeps a nominal fan near 153
  assign tick_limit = 14'(fan_mon_pkg::TICK_CYCLES << meas.div_code);

  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    rise        = 1'b0;
    tick        = (q.pre == tick_limit - 14'h1);
    // A level counts only after it has held steady, so a slow edge gives one transition
    if (tach != q.level) begin
      next_q.filt = q.filt + 8'h01;
      if (q.filt == 8'(fan_mon_pkg::FILT_CYCLES - 1)) begin
        next_q.filt  = 8'h00;
        next_q.level = tach;
        rise         = tach;
      end
    end else begin
      next_q.filt = 8'h00;
    end
    next_q.pre = tick ? 14'h0 : q.pre + 14'h1;
    case (q.st)
      C_IDLE: ;
      C_ARM: begin
        if (rise) begin
          next_q.st    = C_COUNT;
          next_q.count = 8'h00;
          next_q.pre   = 14'h0;
        end else if (tick) begin
          next_q.count = q.count + 8'h01;
        end
      end
      C_COUNT: begin
        if (tick && q.count != fan_mon_pkg::COUNT_MAX) begin
          next_q.count = q.count + 8'h01;
        end
        if (rise) begin
          next_q.st   = C_IDLE;
          next_q.done = 1'b1;
        end
      end
      default: next_q.st = C_IDLE;
    endcase
    // A stopped or missing fan ends at the saturated count
    if (q.st != C_IDLE && q.count == fan_mon_pkg::COUNT_MAX) begin
      next_q.st    = C_IDLE;
      next_q.done  = 1'b1;
      next_q.count = fan_mon_pkg::COUNT_MAX;
    end
    if (meas.start) begin
      next_q.st    = C_ARM;
      next_q.count = 8'h00;
      next_q.pre   = 14'h0;
      next_q.done  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q       <= '0;
      q.st    <= C_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign meas.done  = q.done;
  assign meas.count = q.count;

  chk_start_clears: assert property (@(posedge clk_sys) disable iff (rst)
    meas.start |=> (q.count == 8'h00) && !meas.done)
    else $error("Counter not cleared by start");
  chk_done_single: assert property (@(posedge clk_sys) disable iff (rst)
    meas.done |=> !meas.done)
    else $error("Done pulse longer than one cycle");
  chk_tick_rate: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == C_COUNT && tick && q.count < 8'hFE && !rise && !meas.start)
      |=> q.count == $past(q.count) + 8'h01)
    else $error("Count did not advance on tick");
endmodule : fan_period_counter

// ==== rtl/fan_tach_and_result_readout.sv ====
// Round-robin monitoring loop, result memory and fan period measurement.
// Assumes an external converter that takes a start pulse and answers with done.
// How it works
// - The loop converts temperature, seven analog inputs, then three fans, once a second.
// - Each slot keeps its latest completed result, readable at any time.
// - A host read aborts the conversion in progress and starts it again.
// - Slot results and their update pulse appear only as each slot completes.
// - Analog codes are unsigned 8-bit, 16 mV per step, 4.08 V full scale.
// - A fan counts oscillator ticks over one tach period, saturating at 255.
// - Fan divisors are 1, 2, 4 or 8 and reset to 2.
// - Fans 1 and 2 have programmable divisors; fan 3 is fixed at 2.
// - The stored count is 1.35e6 over the product of RPM and divisor.
// - Tach inputs are filtered so slow edges give exactly one period.
`timescale 1ns/10ps
module fan_tach_and_result_readout #(
  parameter int unsigned LOOP_CYCLES = fan_mon_pkg::LOOP_CYCLES  // Loop period in cycles
) (
  input  wire logic       clk_sys,       // System clock, 50 MHz
  input  wire logic       rst,           // Synchronous reset, active high
  input  wire logic       loop_run,      // Level: monitoring loop enabled
  input  wire logic       div_load,      // Pulse: load fan divisor codes
  input  wire logic [1:0] div_fan1,      // Divisor code for fan 1
  input  wire logic [1:0] div_fan2,      // Divisor code for fan 2
  output logic      [1:0] fan1_div_code, // Current fan 1 divisor code
  output logic      [1:0] fan2_div_code, // Current fan 2 divisor code
  output logic            adc_start,     // Pulse: start conversion on adc_slot
  output logic      [2:0] adc_slot,      // Analog channel being converted
  input  wire logic       adc_done,      // Pulse: conversion finished
  input  wire logic [7:0] adc_code,      // Conversion result
  input  wire logic [2:0] fan_tach,      // Fan tach levels
  input  wire logic       rd_req,        // Pulse: read a result slot
  input  wire logic [3:0] rd_slot,       // Slot to read
  output logic      [7:0] rd_data,       // Read result
  output logic            rd_valid,      // Pulse: rd_data valid
  output logic            slot_done,     // Pulse: a slot was updated
  output logic      [3:0] slot_idx,      // Slot that was updated
  output logic            loop_busy      // Loop is running
);
  typedef enum logic [3:0] {S_IDLE = 4'h1, S_ADC = 4'h2, S_FAN = 4'h4, S_WAIT = 4'h8} loop_st_t;
  typedef struct packed {
    loop_st_t         st;
    logic [3:0]       slot;
    logic [31:0]      timer;
    logic [1:0]       div1;
    logic [1:0]       div2;
    logic [10:0][7:0] mem;
    logic [7:0]       rd_data;
    logic             rd_valid;
    logic             adc_start;
    logic [2:0]       fan_start;
    logic             slot_done;
    logic [3:0]       slot_idx;
  } loop_state_t;

  loop_state_t q, next_q;
  logic [2:0]       fan_done;
  logic [2:0][7:0]  fan_count;
  logic [1:0]       fan_idx;

  fan_meas_if fm[3] ();

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fan
      fan_period_counter u_cnt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tach    (fan_tach[gi]),
        .meas    (fm[gi].counter)
      );
      assign fm[gi].start    = q.fan_start[gi];
      // Fan 3 has no programmable divisor
      assign fm[gi].div_code = (gi == 2) ? fan_mon_pkg::FAN3_DIV :
                               (gi == 0) ? q.div1 : q.div2;
      assign fan_done[gi]    = fm[gi].done;
      assign fan_count[gi]   = fm[gi].count;
    end
  endgenerate

  assign fan_idx = 2'(q.slot - fan_mon_pkg::FAN_FIRST);

  always_comb begin
    next_q           = q;
    next_q.adc_start = 1'b0;
    next_q.fan_start = 3'h0;
    next_q.slot_done = 1'b0;
    next_q.rd_valid  = 1'b0;
    if (q.st != S_IDLE) begin
      next_q.timer = q.timer + 32'h1;
    end
    if (div_load) begin
      next_q.div1 = div_fan1;
      next_q.div2 = div_fan2;
    end
    // Reads see the last completed result; an unmapped slot reads zero
    if (rd_req) begin
      next_q.rd_data  = (rd_slot < 4'(fan_mon_pkg::NUM_SLOTS)) ? q.mem[rd_slot] : 8'h00;
      next_q.rd_valid = 1'b1;
    end
    case (q.st)
      S_IDLE: begin
        if (loop_run) begin
          next_q.st        = S_ADC;
          next_q.slot      = 4'h0;
          next_q.timer     = 32'h0;
          next_q.adc_start = 1'b1;
        end
      end
      S_ADC: begin
        // A read discards the conversion in flight, even one finishing now
        if (rd_req) begin
          next_q.adc_start = 1'b1;
        end else if (adc_done && !q.adc_start) begin
          next_q.mem[q.slot] = adc_code;
          next_q.slot_done   = 1'b1;
          next_q.slot_idx    = q.slot;
          next_q.slot        = q.slot + 4'h1;
          if (q.slot == fan_mon_pkg::LAST_ADC_SLOT) begin
            next_q.st           = S_FAN;
            next_q.fan_start[0] = 1'b1;
          end else begin
            next_q.adc_start = 1'b1;
          end
        end
      end
      S_FAN: begin
        if (fan_done[fan_idx] && q.fan_start == 3'h0) begin
          next_q.mem[q.slot] = fan_count[fan_idx];
          next_q.slot_done   = 1'b1;
          next_q.slot_idx    = q.slot;
          if (q.slot == fan_mon_pkg::LAST_SLOT) begin
            next_q.st = S_WAIT;
          end else begin
            next_q.slot                          = q.slot + 4'h1;
            next_q.fan_start[2'(fan_idx + 2'h1)] = 1'b1;
          end
        end
      end
      S_WAIT: begin
        // Restart only when the full period has passed, keeping the loop near once a second
        if (q.timer >= LOOP_CYCLES - 1) begin
          next_q.st        = S_ADC;
          next_q.slot      = 4'h0;
          next_q.timer     = 32'h0;
          next_q.adc_start = 1'b1;
        end
      end
      default: next_q.st = S_IDLE;
    endcase
    if (!loop_run) begin
      next_q.st        = S_IDLE;
      next_q.adc_start = 1'b0;
      next_q.fan_start = 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q      <= '0;
      q.st   <= S_IDLE;
      q.div1 <= fan_mon_pkg::DIV_RESET;
      q.div2 <= fan_mon_pkg::DIV_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign fan1_div_code = q.div1;
  assign fan2_div_code = q.div2;
  assign adc_start     = q.adc_start;
  assign adc_slot      = q.slot[2:0];
  assign rd_data       = q.rd_data;
  assign rd_valid      = q.rd_valid;
  assign slot_done     = q.slot_done;
  assign slot_idx      = q.slot_idx;
  assign loop_busy     = (q.st != S_IDLE);

  chk_read_returns: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_req && rd_slot < 4'hB) |=> rd_valid && rd_data == $past(q.mem[rd_slot]))
    else $error("Read did not return stored result");
  chk_read_restart: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_req && q.st == S_ADC && loop_run) |=> adc_start && !slot_done)
    else $error("Read did not restart conversion");
  chk_fan_store: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_FAN && fan_done[fan_idx] && q.fan_start == 3'h0 && loop_run)
      |=> slot_done && q.mem[slot_idx] == $past(fan_count[fan_idx]))
    else $error("Fan count not stored at slot end");
  chk_div_reset: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(rst) && !$past(div_load)) |-> fan1_div_code == 2'h1 && fan2_div_code == 2'h1)
    else $error("Divisor not reset to 2");
  chk_fan3_fixed: assert property (@(posedge clk_sys) disable iff (rst)
    g_fan[2].u_cnt.tick_limit == 14'(fan_mon_pkg::TICK_CYCLES << 1))
    else $error("Fan 3 divisor not fixed");
  chk_slot_update: assert property (@(posedge clk_sys) disable iff (rst)
    slot_done |-> slot_idx <= 4'hA && ($past(adc_done) || $past(|fan_done)))
    else $error("Slot update without completion");

  // Loop sequencing: a stop is immediate, a restart waits out the full period
  chk_stop_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !loop_run |=> !loop_busy && !adc_start)
    else $error("Loop did not stop");
  chk_loop_period: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_WAIT && q.timer >= LOOP_CYCLES - 1 && loop_run)
      |=> adc_start && adc_slot == 3'h0)
    else $error("Loop did not restart at slot 0");
  chk_loop_early: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_WAIT && q.timer < LOOP_CYCLES - 1) |=> !adc_start)
    else $error("Loop restarted before its period");

  // Converter answers land in their own slot, and the last one hands over to fan 1
  chk_adc_store: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_ADC && adc_done && !q.adc_start && !rd_req && loop_run)
      |=> slot_done && slot_idx == $past(q.slot) && q.mem[slot_idx] == $past(adc_code))
    else $error("Conversion not stored in its slot");
  chk_fan_start: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_ADC && adc_done && !q.adc_start && !rd_req && loop_run
      && q.slot == fan_mon_pkg::LAST_ADC_SLOT) |=> q.st == S_FAN && fm[0].start)
    else $error("Fan 1 measurement not started after last conversion");
  chk_read_source: assert property (@(posedge clk_sys) disable iff (rst)
    rd_valid |-> $past(rd_req))
    else $error("Read answer without a request");
endmodule : fan_tach_and_result_readout
